//--- rtl/cas_arch_state.sv
// Architectural register state of the execution unit with an APB port.
`timescale 1ns/1ps

// Overview of operation
// - Eight 16-bit general registers; first four also written as byte halves.
// - Four 16-bit segment registers: code, data, stack, extra.
// - Reset loads the code segment with FFFF.
// - Reset clears data, stack and extra segments.
// - Instruction pointer resets to zero; first fetch is at FFFF0.
// - Software cannot read or write the instruction pointer.
// - Flags word is 16 bits, resets to zero, reserved bits stay zero.
// - Signed arithmetic overflow sets the overflow flag.
// - Direction flag set steps string addresses up, clear steps down.
// - Maskable interrupt requests pass only while interrupt enable is set.
// - Trace flag raises a debug event after each instruction.
// - Sign flag copies the result's top bit.
// - Zero flag is set for a zero result, cleared otherwise.
// - Count low byte gives the variable shift and rotate amount.
// - Count register is the loop and repeat iteration counter.
// - Data extension register gives port address and upper product half.
// - Auxiliary carry marks carry or borrow at the low nibble.
// - Parity flag is set for even ones in the low result byte.
// - Carry flag marks carry out of or borrow into the top bit.
// - Segment and offset form a 20-bit physical address.
module cas_arch_state (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cas_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cas_pkg::cas_alu_req_t aluReq,
    input wire cas_pkg::cas_gpr_wr_t gprWr,
    input wire logic [2:0] gprRdIdx,
    input wire logic segWrEn,
    input wire logic [1:0] segWrIdx,
    input wire logic [15:0] segWrData,
    input wire logic mulDivWrEn,
    input wire logic [31:0] mulDivResult,
    input wire logic countDec,
    input wire logic strStep,
    input wire logic strWord,
    input wire logic strSrcEn,
    input wire logic strDstEn,
    input wire logic flagsLoadEn,
    input wire logic [15:0] flagsLoadData,
    input wire cas_pkg::cas_flag_ctl_t flagCtl,
    input wire logic instrDone,
    input wire logic intReq,
    input wire logic ipLoadEn,
    input wire logic [15:0] ipLoadData,
    input wire logic ipAdvance,
    input wire logic [3:0] ipAdvanceBytes,
    input wire logic agValid,
    input wire logic [1:0] agSegIdx,
    input wire logic [15:0] agOffset,
    output logic [15:0] gprRdData,
    output logic [15:0] aluResult,
    output cas_pkg::cas_flags_t flagsOut,
    output logic [7:0] shiftCount,
    output logic countIsZero,
    output logic [15:0] ioPortAddr,
    output logic intAccept,
    output logic traceExc,
    output logic [19:0] fetchAddr,
    output logic [19:0] physAddr,
    output logic physAddrValid
);
    import cas_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [15:0] gpr_q [8];
    logic [15:0] gpr_d [8];
    logic [15:0] seg_q [4];
    logic [15:0] seg_d [4];
    logic [15:0] ip_q;
    logic [15:0] ip_d;
    cas_flags_t flags_q;
    cas_flags_t flags_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [15:0] gprRdData_q;
    logic [15:0] aluResult_q;
    logic countIsZero_q;
    logic intAccept_q;
    logic traceExc_q;
    logic [19:0] physAddr_q;
    logic physAddrValid_q;
    logic [19:0] fetchAddr_q;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire aligned = (paddr[1:0] == 2'b00);
    wire hitGpr = aligned && (paddr[7:5] == OFS_GPR_BASE[7:5]);
    wire hitSeg = aligned && (paddr[7:4] == OFS_SEG_BASE[7:4]);
    wire hitFlags = (paddr == OFS_FLAGS);
    wire hitFetch = (paddr == OFS_FETCH);
    wire hitAny = hitGpr || hitSeg || hitFlags || hitFetch;
    wire [2:0] apbGprIdx = paddr[4:2];
    wire [1:0] apbSegIdx = paddr[3:2];
    wire apbSetup = psel && !penable;
    wire apbCommit = psel && penable && pready_q;
    wire apbWrite = apbCommit && pwrite && !pslverr_q;
    wire [15:0] apbWord = pwdata[15:0];
    // The instruction pointer has no address of its own; only the derived
    // fetch address is visible, read-only.
    wire [19:0] fetchAddrW = {seg_q[SEG_CODE], 4'h0} + {4'h0, ip_q};
    wire [15:0] rdGpr = gpr_q[apbGprIdx];
    wire [15:0] rdSeg = seg_q[apbSegIdx];
    wire [31:0] rdMux = hitGpr ? {16'h0000, rdGpr} :
        hitSeg ? {16'h0000, rdSeg} :
        hitFlags ? {16'h0000, flags_q} :
        hitFetch ? {12'h000, fetchAddrW} : 32'h0000_0000;

    // ****************************************************************
    // Address generation
    // ****************************************************************
    wire [19:0] agAddrW = {seg_q[agSegIdx], 4'h0} + {4'h0, agOffset};
    // The fetch output is registered from the next values, so it still
    // tracks the code segment and pointer in the same cycle.
    wire [19:0] fetchAddrD = {seg_d[SEG_CODE], 4'h0} + {4'h0, ip_d};

    // ****************************************************************
    // Arithmetic flag generation
    // ****************************************************************
    wire [15:0] byteMask = aluReq.byteOp ? 16'h00FF : 16'hFFFF;
    wire [15:0] opA = aluReq.opA & byteMask;
    wire [15:0] opB = aluReq.opB & byteMask;
    wire [16:0] sumAdd = {1'b0, opA} + {1'b0, opB} + {16'h0000, aluReq.carryIn};
    wire [16:0] sumSub = {1'b0, opA} - {1'b0, opB} - {16'h0000, aluReq.carryIn};
    wire [16:0] sum = (aluReq.op == ALU_SUB) ? sumSub :
        (aluReq.op == ALU_ADD) ? sumAdd : {1'b0, opA};
    wire [15:0] res = sum[15:0] & byteMask;
    // A borrow leaves the bit above the operand set, just like a carry.
    wire carryW = aluReq.byteOp ? sum[8] : sum[16];
    wire aMsb = aluReq.byteOp ? opA[7] : opA[15];
    wire bMsb = aluReq.byteOp ? opB[7] : opB[15];
    wire rMsb = aluReq.byteOp ? res[7] : res[15];
    wire ovfAdd = (aMsb == bMsb) && (rMsb != aMsb);
    wire ovfSub = (aMsb != bMsb) && (rMsb != aMsb);
    wire ovfW = (aluReq.op == ALU_SUB) ? ovfSub : ovfAdd;
    wire auxW = opA[4] ^ opB[4] ^ res[4];
    wire zeroW = (res == 16'h0000);
    wire parityW = ~^res[7:0];
    wire isArith = (aluReq.op != ALU_PASS);

    always_comb begin
        flags_d = flags_q;
        if (apbWrite && hitFlags) begin
            flags_d = cas_flags_t'(apbWord & FLAGS_IMPL_MASK);
        end
        if (flagsLoadEn) begin
            flags_d = cas_flags_t'(flagsLoadData & FLAGS_IMPL_MASK);
        end
        if (flagCtl.setDir) begin
            flags_d.directionFlag = 1'b1;
        end
        if (flagCtl.clrDir) begin
            flags_d.directionFlag = 1'b0;
        end
        if (flagCtl.setIntEn) begin
            flags_d.intEnableFlag = 1'b1;
        end
        if (flagCtl.clrIntEn) begin
            flags_d.intEnableFlag = 1'b0;
        end
        if (aluReq.valid) begin
            flags_d.signFlag = rMsb;
            flags_d.zeroFlag = zeroW;
            flags_d.parityFlag = parityW;
            flags_d.carryFlag = isArith && carryW;
            flags_d.overflowFlag = isArith && ovfW;
            if (isArith) begin
                flags_d.auxCarryFlag = auxW;
            end
        end
    end

    // ****************************************************************
    // String stepping and general register next values
    // ****************************************************************
    wire [15:0] strSize = strWord ? 16'h0002 : 16'h0001;
    wire [15:0] strDelta = flags_q.directionFlag ? strSize : -strSize;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gpr
            localparam logic [2:0] IDX = 3'(gi);
            wire apbHit = apbWrite && hitGpr && (apbGprIdx == IDX);
            wire exeHit = gprWr.valid && (gprWr.idx == IDX);
            wire halves = (gi < 4);
            always_comb begin
                gpr_d[gi] = gpr_q[gi];
                if (apbHit) begin
                    gpr_d[gi] = apbWord;
                end
                if (exeHit && gprWr.byteOp && halves && gprWr.highHalf) begin
                    gpr_d[gi][15:8] = gprWr.data[7:0];
                end else if (exeHit && gprWr.byteOp && halves) begin
                    gpr_d[gi][7:0] = gprWr.data[7:0];
                end else if (exeHit) begin
                    gpr_d[gi] = gprWr.data;
                end
                if (mulDivWrEn && IDX == GPR_ACC) begin
                    gpr_d[gi] = mulDivResult[15:0];
                end
                if (mulDivWrEn && IDX == GPR_DATA) begin
                    gpr_d[gi] = mulDivResult[31:16];
                end
                if (countDec && IDX == GPR_COUNT) begin
                    gpr_d[gi] = gpr_q[gi] - 16'h0001;
                end
                if (strStep && strSrcEn && IDX == GPR_SRC) begin
                    gpr_d[gi] = gpr_q[gi] + strDelta;
                end
                if (strStep && strDstEn && IDX == GPR_DST) begin
                    gpr_d[gi] = gpr_q[gi] + strDelta;
                end
            end
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    gpr_q[gi] <= RST_GPR;
                end else begin
                    gpr_q[gi] <= gpr_d[gi];
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_seg
            localparam logic [1:0] IDX = 2'(gi);
            localparam logic [15:0] RST =
                (IDX == SEG_CODE) ? RST_CODE_SEG : RST_OTHER_SEG;
            always_comb begin
                seg_d[gi] = seg_q[gi];
                if (apbWrite && hitSeg && apbSegIdx == IDX) begin
                    seg_d[gi] = apbWord;
                end
                if (segWrEn && segWrIdx == IDX) begin
                    seg_d[gi] = segWrData;
                end
            end
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    seg_q[gi] <= RST;
                end else begin
                    seg_q[gi] <= seg_d[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Instruction pointer
    // ****************************************************************
    // Only the bus interface unit and program flow reach this register.
    always_comb begin
        ip_d = ip_q;
        if (ipAdvance) begin
            ip_d = ip_q + {12'h000, ipAdvanceBytes};
        end
        if (ipLoadEn) begin
            ip_d = ipLoadData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ip_q <= RST_IP;
            flags_q <= RST_FLAGS;
        end else begin
            ip_q <= ip_d;
            flags_q <= flags_d;
        end
    end

    // ****************************************************************
    // APB slave: no wait states, pready rises in the access phase
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apbSetup;
            pslverr_q <= apbSetup && !hitAny;
            prdata_q <= (apbSetup && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Execution-side outputs
    // ****************************************************************
    // Trace uses the flag as it stood before this instruction retired, so
    // a flags pop or interrupt return that sets it first traps one
    // instruction later.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            gprRdData_q <= RST_GPR;
            aluResult_q <= 16'h0000;
            countIsZero_q <= 1'b1;
            intAccept_q <= 1'b0;
            traceExc_q <= 1'b0;
            physAddr_q <= 20'h00000;
            physAddrValid_q <= 1'b0;
            fetchAddr_q <= {RST_CODE_SEG, 4'h0};
        end else begin
            gprRdData_q <= gpr_d[gprRdIdx];
            aluResult_q <= aluReq.valid ? res : aluResult_q;
            countIsZero_q <= (gpr_d[GPR_COUNT] == 16'h0000);
            intAccept_q <= intReq && flags_q.intEnableFlag;
            traceExc_q <= instrDone && flags_q.traceFlag;
            physAddr_q <= agValid ? agAddrW : physAddr_q;
            physAddrValid_q <= agValid;
            fetchAddr_q <= fetchAddrD;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gprRdData = gprRdData_q;
    assign aluResult = aluResult_q;
    assign flagsOut = flags_q;
    assign shiftCount = gpr_q[GPR_COUNT][7:0];
    assign countIsZero = countIsZero_q;
    assign ioPortAddr = gpr_q[GPR_DATA];
    assign intAccept = intAccept_q;
    assign traceExc = traceExc_q;
    assign fetchAddr = fetchAddr_q;
    assign physAddr = physAddr_q;
    assign physAddrValid = physAddrValid_q;

endmodule

//--- rtl/cas_pkg.sv
// Shared constants and types for the architectural register state block.
package cas_pkg;

    // ****************************************************************
    // Register bus map
    // ****************************************************************
    localparam int APB_ADDR_W = 8;
    localparam logic [7:0] OFS_GPR_BASE = 8'h00;
    localparam logic [7:0] OFS_SEG_BASE = 8'h20;
    localparam logic [7:0] OFS_FLAGS = 8'h30;
    localparam logic [7:0] OFS_FETCH = 8'h34;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [2:0] GPR_ACC = 3'h0;
    localparam logic [2:0] GPR_COUNT = 3'h1;
    localparam logic [2:0] GPR_DATA = 3'h2;
    localparam logic [2:0] GPR_BASE = 3'h3;
    localparam logic [2:0] GPR_STACK = 3'h4;
    localparam logic [2:0] GPR_FRAME = 3'h5;
    localparam logic [2:0] GPR_SRC = 3'h6;
    localparam logic [2:0] GPR_DST = 3'h7;
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_CODE = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;

    // ****************************************************************
    // Reset values and field layout
    // ****************************************************************
    localparam logic [15:0] RST_CODE_SEG = 16'hFFFF;
    localparam logic [15:0] RST_OTHER_SEG = 16'h0000;
    localparam logic [15:0] RST_GPR = 16'h0000;
    localparam logic [15:0] RST_IP = 16'h0000;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [15:0] FLAGS_IMPL_MASK = 16'h0FD5;
    localparam int SEG_SHIFT = 4;

    typedef struct packed {
        logic [3:0] rsvdHi;
        logic overflowFlag;
        logic directionFlag;
        logic intEnableFlag;
        logic traceFlag;
        logic signFlag;
        logic zeroFlag;
        logic rsvd5;
        logic auxCarryFlag;
        logic rsvd3;
        logic parityFlag;
        logic rsvd1;
        logic carryFlag;
    } cas_flags_t;

    typedef enum logic [1:0] {
        ALU_ADD,
        ALU_SUB,
        ALU_PASS
    } cas_alu_op_t;

    typedef struct packed {
        logic valid;
        cas_alu_op_t op;
        logic byteOp;
        logic carryIn;
        logic [15:0] opA;
        logic [15:0] opB;
    } cas_alu_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic byteOp;
        logic highHalf;
        logic [15:0] data;
    } cas_gpr_wr_t;

    typedef struct packed {
        logic setDir;
        logic clrDir;
        logic setIntEn;
        logic clrIntEn;
    } cas_flag_ctl_t;

endpackage

//--- sim/cas_arch_state_checker.sv
// Concurrent property checks at the ports of the register state block.
`timescale 1ns/1ps
module cas_arch_state_checker
    import cas_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pready,
    input wire logic pslverr,
    input wire cas_pkg::cas_alu_req_t aluReq,
    input wire logic instrDone,
    input wire logic intReq,
    input wire logic agValid,
    input wire logic [15:0] aluResult,
    input wire cas_pkg::cas_flags_t flagsOut,
    input wire logic intAccept,
    input wire logic traceExc,
    input wire logic [19:0] fetchAddr,
    input wire logic physAddrValid
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // The ALU owns the flags in the cycle after a request, as it wins
    // every same-cycle conflict, so its flag bits follow aluResult.
    property p_parity;
        aluReq.valid |=> flagsOut.parityFlag == ~^aluResult[7:0];
    endproperty

    a_ready_single: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rsvd_zero: assert property (
        (flagsOut & ~FLAGS_IMPL_MASK) == 16'h0000)
        else $error("reserved flag bit set");
    a_fetch_reset: assert property (
        $fell(reset) |-> fetchAddr == 20'hFFFF0)
        else $error("first fetch address wrong after reset");
    a_int_gate: assert property (
        !reset |=> intAccept == $past(intReq && flagsOut.intEnableFlag))
        else $error("interrupt acceptance does not follow enable");
    a_trace_event: assert property (
        !reset |=> traceExc == $past(instrDone && flagsOut.traceFlag))
        else $error("trace event does not follow trace flag");
    a_addr_valid: assert property (
        !reset |=> physAddrValid == $past(agValid))
        else $error("address valid not one cycle after request");
    a_zero_flag: assert property (
        aluReq.valid |=> flagsOut.zeroFlag == (aluResult == 16'h0000))
        else $error("zero flag does not match result");
    a_sign_flag: assert property (
        aluReq.valid |=> flagsOut.signFlag ==
        ($past(aluReq.byteOp) ? aluResult[7] : aluResult[15]))
        else $error("sign flag does not match result top bit");
    a_parity_flag: assert property (p_parity)
        else $error("parity flag does not match low result byte");

    c_int: cover property (intAccept);
    c_trace: cover property (traceExc);
    c_err: cover property (pslverr);
    c_byte_alu: cover property (aluReq.valid && aluReq.byteOp);
endmodule

bind cas_arch_state cas_arch_state_checker i_chk (
    .core_clk, .reset, .pready, .pslverr, .aluReq, .instrDone, .intReq,
    .agValid, .aluResult, .flagsOut, .intAccept, .traceExc, .fetchAddr,
    .physAddrValid
);

//--- sim/testbench.sv
// Self-checking bench for the architectural register state block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
fails++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module testbench;
    import cas_pkg::*;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, mulDivResult = 32'h0;
    cas_alu_req_t aluReq = 37'h0;
    cas_gpr_wr_t gprWr = 22'h0;
    cas_flag_ctl_t flagCtl = 4'h0;
    logic [2:0] gprRdIdx = GPR_BASE;
    logic segWrEn = 1'h0, mulDivWrEn = 1'h0, countDec = 1'h0;
    logic strStep = 1'h0, strWord = 1'h0, strSrcEn = 1'h0, strDstEn = 1'h0;
    logic flagsLoadEn = 1'h0, instrDone = 1'h0, intReq = 1'h0;
    logic ipLoadEn = 1'h0, ipAdvance = 1'h0, agValid = 1'h0;
    logic [1:0] segWrIdx = 2'h0, agSegIdx = 2'h0;
    logic [15:0] segWrData = 16'h0, flagsLoadData = 16'h0;
    logic [15:0] ipLoadData = 16'h0, agOffset = 16'h0;
    logic [3:0] ipAdvanceBytes = 4'h0;
    logic [15:0] gprRdData, aluResult, ioPortAddr;
    logic [31:0] prdata;
    logic pready, pslverr, countIsZero, intAccept, traceExc, physAddrValid;
    cas_flags_t flagsOut;
    logic [7:0] shiftCount;
    logic [19:0] fetchAddr, physAddr, expPa;
    logic [32:0] rdQ[$], expRd;
    logic [19:0] paQ[$];
    logic [31:0] r;
    logic [15:0] gv[8];
    int fails = 0, compares = 0;
    // Each row is an ALU request; the flag row holds the whole flags word.
    cas_alu_req_t aluTab[7] = '{
        '{1'h1, ALU_ADD, 1'h0, 1'h0, 16'hFFFF, 16'h0001},
        '{1'h1, ALU_SUB, 1'h0, 1'h0, 16'h0000, 16'h0001},
        '{1'h1, ALU_ADD, 1'h0, 1'h0, 16'h7FFF, 16'h0001},
        '{1'h1, ALU_SUB, 1'h0, 1'h0, 16'h8000, 16'h0001},
        '{1'h1, ALU_PASS, 1'h0, 1'h0, 16'h0003, 16'h0000},
        '{1'h1, ALU_ADD, 1'h1, 1'h0, 16'h00FF, 16'h0001},
        '{1'h1, ALU_ADD, 1'h0, 1'h1, 16'h0000, 16'h0000}};
    logic [15:0] aluFl[7] = '{16'h0055, 16'h0095, 16'h0894, 16'h0814,
        16'h0014, 16'h0055, 16'h0000};

    cas_arch_state i_dut (
        .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .aluReq, .gprWr, .gprRdIdx, .segWrEn,
        .segWrIdx, .segWrData, .mulDivWrEn, .mulDivResult, .countDec,
        .strStep, .strWord, .strSrcEn, .strDstEn, .flagsLoadEn,
        .flagsLoadData, .flagCtl, .instrDone, .intReq, .ipLoadEn,
        .ipLoadData, .ipAdvance, .ipAdvanceBytes, .agValid, .agSegIdx,
        .agOffset, .gprRdData, .aluResult, .flagsOut, .shiftCount,
        .countIsZero, .ioPortAddr, .intAccept, .traceExc, .fetchAddr,
        .physAddr, .physAddrValid
    );

    always #5 core_clk = ~core_clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic finish_test();
        if (rdQ.size() != 0 || paQ.size() != 0) fails++;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge core_clk);
    endtask

    // An idle cycle follows every transfer so psel is never driven twice
    // in one time step when transfers are issued back to back.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) rdQ.push_back(e);
        tick();
        penable <= 1'h1;
        for (n = 0; n < 16; n++) begin
            tick();
            if (pready === 1'h1) break;
        end
        if (n == 16) begin
            fails++;
            finish_test();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        tick();
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'h0, a, 32'h0, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 33'h0);
    endtask

    // ****************************************************************
    // Result monitor
    // ****************************************************************
    always @(posedge core_clk) begin
        if (psel && penable && !pwrite && pready === 1'h1) begin
            expRd = rdQ.size() != 0 ? rdQ.pop_front() : 33'h0;
            `CHK("prdata", expRd, {pslverr, prdata})
        end
        if (physAddrValid === 1'h1) begin
            expPa = paQ.size() != 0 ? paQ.pop_front() : 20'hFFFFF;
            `CHK("physAddr", expPa, physAddr)
        end
    end

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        void'($urandom(32'h3837));
        repeat (5) tick();
        reset <= 1'h0;
        tick();
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 33'h0);
        rd(8'h20, 33'h0);
        rd(8'h24, 33'h0FFFF);
        rd(8'h28, 33'h0);
        rd(8'h2C, 33'h0);
        rd(OFS_FLAGS, 33'h0);
        rd(OFS_FETCH, 33'hFFFF0);
        rd(8'h38, 33'h100000000);
        rd(8'h02, 33'h100000000);
        wr(OFS_FETCH, 32'h00012345);
        rd(OFS_FETCH, 33'hFFFF0);
        for (int i = 0; i < 7; i++) begin
            aluReq <= aluTab[i];
            tick();
            aluReq.valid <= 1'h0;
            rd(OFS_FLAGS, {17'h0, aluFl[i]});
        end
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            gv[i] = r[15:0];
            wr(8'(4 * i), r);
            rd(8'(4 * i), {17'h0, gv[i]});
        end
        gprWr <= '{1'h1, GPR_BASE, 1'h1, 1'h1, 16'h00A5};
        tick();
        gprWr.valid <= 1'h0;
        rd(8'h0C, {17'h0, 8'hA5, gv[3][7:0]});
        `CHK("gprRdData", {8'hA5, gv[3][7:0]}, gprRdData)
        wr(8'h04, 32'h00000001);
        countDec <= 1'h1;
        tick();
        countDec <= 1'h0;
        rd(8'h04, 33'h0);
        `CHK("countIsZero", 1'h1, countIsZero)
        wr(8'h04, r);
        `CHK("shiftCount", r[7:0], shiftCount)
        r = $urandom;
        mulDivResult <= r;
        mulDivWrEn <= 1'h1;
        tick();
        mulDivWrEn <= 1'h0;
        rd(8'h00, {17'h0, r[15:0]});
        rd(8'h08, {17'h0, r[31:16]});
        `CHK("ioPortAddr", r[31:16], ioPortAddr)
        wr(8'h18, 32'h00000100);
        flagCtl <= 4'h8;
        tick();
        flagCtl <= 4'h0;
        strStep <= 1'h1;
        strWord <= 1'h1;
        strSrcEn <= 1'h1;
        strDstEn <= 1'h1;
        tick();
        strStep <= 1'h0;
        rd(8'h18, 33'h0102);
        rd(8'h1C, {17'h0, gv[7] + 16'h0002});
        flagCtl <= 4'h4;
        strWord <= 1'h0;
        tick();
        flagCtl <= 4'h0;
        strStep <= 1'h1;
        tick();
        strStep <= 1'h0;
        rd(8'h18, 33'h0101);
        wr(OFS_FLAGS, 32'hFFFFFFFF);
        rd(OFS_FLAGS, 33'h0FD5);
        intReq <= 1'h1;
        tick();
        flagCtl <= 4'h1;
        tick();
        flagCtl <= 4'h2;
        tick();
        flagCtl <= 4'h0;
        intReq <= 1'h0;
        flagsLoadData <= 16'hF100;
        flagsLoadEn <= 1'h1;
        tick();
        flagsLoadEn <= 1'h0;
        rd(OFS_FLAGS, 33'h0100);
        instrDone <= 1'h1;
        tick();
        instrDone <= 1'h0;
        tick();
        `CHK("traceExc", 1'h1, traceExc)
        wr(OFS_FLAGS, 32'h0);
        ipAdvanceBytes <= 4'h3;
        ipAdvance <= 1'h1;
        tick();
        ipAdvance <= 1'h0;
        rd(OFS_FETCH, 33'hFFFF3);
        ipLoadData <= 16'h0010;
        ipLoadEn <= 1'h1;
        ipAdvance <= 1'h1;
        tick();
        ipLoadEn <= 1'h0;
        ipAdvance <= 1'h0;
        rd(OFS_FETCH, 33'h0);
        segWrIdx <= SEG_DATA;
        segWrData <= 16'h1234;
        segWrEn <= 1'h1;
        tick();
        segWrEn <= 1'h0;
        rd(8'h2C, 33'h1234);
        r = $urandom;
        paQ.push_back(20'h12340 + {4'h0, r[15:0]});
        paQ.push_back(20'h00000);
        agSegIdx <= SEG_DATA;
        agOffset <= r[15:0];
        agValid <= 1'h1;
        tick();
        agSegIdx <= SEG_CODE;
        agOffset <= 16'h0010;
        tick();
        agValid <= 1'h0;
        repeat (3) tick();
        reset <= 1'h1;
        repeat (2) tick();
        reset <= 1'h0;
        tick();
        rd(8'h24, 33'h0FFFF);
        rd(8'h2C, 33'h0);
        rd(8'h00, 33'h0);
        finish_test();
    end
endmodule
